// ===== design/olc_ctrl_status.sv
`timescale 1ns/1ps
`default_nettype none
`include "olc_regs.svh"

// Operation
// - Identity register returns a fixed 8-bit id and revision value.
// - Analog loopback bits enable loopback per channel, reset zero.
// - Remote loopback bits enable loopback per channel, reset zero.
// - Force-ones bits make channel transmit all ones, reset zero.
// - Signal-absent status shows per-channel loss of signal, reset zero.
// - Driver-fault status shows per-channel driver fault, reset zero.
// - Signal-absent mask bits permit that channel's interrupts, reset zero.
// - Driver-fault mask bits permit that channel's interrupts, reset zero.
// - Signal-absent flag sets on any status edge when masked in.
// - Signal-absent flags clear on status read and at reset.
// - Driver-fault flag sets on masked edge, clears on status read.
// - Any soft reset write starts 1 us reset of all registers except expanded indicator status.
// - Soft reset register keeps all-ones content regardless of writes.
module olc_ctrl_status
  import olc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic host_rd,
  input wire logic host_wr,
  input wire logic [4:0] host_addr,
  input wire logic [7:0] host_wdata,
  input wire logic [7:0] channel_signal_absent,
  input wire logic [7:0] channel_driver_fault,
  input wire logic [7:0] expanded_indicator_status,
  output logic [7:0] host_rdata,
  output var olc_ctrl_t line_ctrl,
  output logic irq_req,
  output logic soft_reset_busy
);

  // Registered state and its next value
  olc_state_t st;
  olc_state_t next_st;

  // Host request, driven on this clock
  olc_bus_req_t req;

  // One hit per mapped address
  logic hit_id;

  logic hit_analog;
  logic hit_remote;
  logic hit_ones;

  logic hit_sa_status;
  logic hit_drv_status;

  logic hit_sa_mask;
  logic hit_drv_mask;

  logic hit_sa_flag;
  logic hit_drv_flag;

  logic hit_soft_reset;

  logic hit_xis;
  logic hit_cfg_0e;
  logic hit_cfg_0f;
  logic hit_page;

  // Qualified strobes
  logic rd_any;
  logic wr_any;

  logic rd_sa_status;
  logic rd_drv_status;

  logic wr_analog;
  logic wr_remote;
  logic wr_ones;

  logic wr_sa_mask;
  logic wr_drv_mask;

  logic wr_soft_reset;

  logic wr_cfg_0e;
  logic wr_cfg_0f;
  logic wr_page;

  // Per-channel flag terms
  logic [7:0] sa_changed;
  logic [7:0] sa_edge_set;
  logic [7:0] sa_flag_kept;
  logic [7:0] sa_flag_new;

  logic [7:0] drv_changed;
  logic [7:0] drv_edge_set;
  logic [7:0] drv_flag_kept;
  logic [7:0] drv_flag_new;

  // Soft reset counter terms
  logic rst_last_cycle;
  logic [7:0] rst_cnt_dec;
  logic [7:0] rst_cnt_load;

  assign req = '{rd: host_rd, wr: host_wr, addr: host_addr, wdata: host_wdata};

  // Address decode
  assign hit_id = (req.addr == `OLC_ADDR_ID);

  assign hit_analog = (req.addr == `OLC_ADDR_ANALOG);
  assign hit_remote = (req.addr == `OLC_ADDR_REMOTE);
  assign hit_ones = (req.addr == `OLC_ADDR_ONES);

  assign hit_sa_status = (req.addr == `OLC_ADDR_SAS);
  assign hit_drv_status = (req.addr == `OLC_ADDR_DRVS);

  assign hit_sa_mask = (req.addr == `OLC_ADDR_SAM);
  assign hit_drv_mask = (req.addr == `OLC_ADDR_DRVM);

  assign hit_sa_flag = (req.addr == `OLC_ADDR_SAF);
  assign hit_drv_flag = (req.addr == `OLC_ADDR_DRVF);

  assign hit_soft_reset = (req.addr == `OLC_ADDR_SRST);

  assign hit_xis = (req.addr == `OLC_ADDR_XIS);
  assign hit_cfg_0e = (req.addr == `OLC_ADDR_XC0E);
  assign hit_cfg_0f = (req.addr == `OLC_ADDR_XC0F);
  assign hit_page = (req.addr == `OLC_ADDR_PAGE);

  // Strobes
  assign rd_any = req.rd;
  assign wr_any = req.wr;

  assign rd_sa_status = rd_any & hit_sa_status;
  assign rd_drv_status = rd_any & hit_drv_status;

  assign wr_analog = wr_any & hit_analog;
  assign wr_remote = wr_any & hit_remote;
  assign wr_ones = wr_any & hit_ones;

  assign wr_sa_mask = wr_any & hit_sa_mask;
  assign wr_drv_mask = wr_any & hit_drv_mask;

  assign wr_soft_reset = wr_any & hit_soft_reset;

  assign wr_cfg_0e = wr_any & hit_cfg_0e;
  assign wr_cfg_0f = wr_any & hit_cfg_0f;
  assign wr_page = wr_any & hit_page;

  // Reset cycle counter
  assign rst_last_cycle = (st.rst_cnt == 8'h00);
  assign rst_cnt_dec = st.rst_cnt - 8'h01;
  assign rst_cnt_load = 8'(`OLC_SOFT_RESET_CYC - 1);

  // Edge sets a flag when masked in; set beats a same-cycle read-clear
  for (genvar ch = 0; ch < 8; ch++) begin : g_chan
    assign sa_changed[ch] = st.sa_sync[ch] ^ st.sa_stat[ch];
    assign sa_edge_set[ch] = sa_changed[ch] & st.sa_mask[ch];
    assign sa_flag_kept[ch] = st.sa_flag[ch] & ~rd_sa_status;
    assign sa_flag_new[ch] = sa_flag_kept[ch] | sa_edge_set[ch];

    assign drv_changed[ch] = st.drv_sync[ch] ^ st.drv_stat[ch];
    assign drv_edge_set[ch] = drv_changed[ch] & st.drv_mask[ch];
    assign drv_flag_kept[ch] = st.drv_flag[ch] & ~rd_drv_status;
    assign drv_flag_new[ch] = drv_flag_kept[ch] | drv_edge_set[ch];
  end : g_chan

  always_comb begin
    next_st = st;

    // Line inputs pass two flops before anything reads them
    next_st.sa_meta = channel_signal_absent;
    next_st.sa_sync = st.sa_meta;

    next_st.drv_meta = channel_driver_fault;
    next_st.drv_sync = st.drv_meta;

    next_st.xis_meta = expanded_indicator_status;
    next_st.xis_sync = st.xis_meta;

    // Status follows the synchronised pins
    next_st.sa_stat = st.sa_sync;
    next_st.drv_stat = st.drv_sync;

    // Read data stands for one cycle, zero otherwise
    next_st.rdata = `OLC_RST_ZERO;
    if (rd_any) begin
      case (req.addr)
        `OLC_ADDR_ID: begin
          next_st.rdata = `OLC_ID_DEFAULT;
        end

        `OLC_ADDR_ANALOG: begin
          next_st.rdata = st.ctrl.analog_loop;
        end

        `OLC_ADDR_REMOTE: begin
          next_st.rdata = st.ctrl.remote_loop;
        end

        `OLC_ADDR_ONES: begin
          next_st.rdata = st.ctrl.force_ones;
        end

        `OLC_ADDR_SAS: begin
          next_st.rdata = st.sa_stat;
        end

        `OLC_ADDR_DRVS: begin
          next_st.rdata = st.drv_stat;
        end

        `OLC_ADDR_SAM: begin
          next_st.rdata = st.sa_mask;
        end

        `OLC_ADDR_DRVM: begin
          next_st.rdata = st.drv_mask;
        end

        `OLC_ADDR_SAF: begin
          next_st.rdata = st.sa_flag;
        end

        `OLC_ADDR_DRVF: begin
          next_st.rdata = st.drv_flag;
        end

        `OLC_ADDR_SRST: begin
          next_st.rdata = `OLC_RST_TRIGGER_VAL;
        end

        `OLC_ADDR_XIS: begin
          next_st.rdata = st.xis_sync;
        end

        `OLC_ADDR_XC0E: begin
          next_st.rdata = st.x0e;
        end

        `OLC_ADDR_XC0F: begin
          next_st.rdata = st.x0f;
        end

        `OLC_ADDR_PAGE: begin
          next_st.rdata = st.page;
        end

        default: begin
          next_st.rdata = `OLC_RST_ZERO;
        end
      endcase
    end

    // Flags cleared by status read, set by masked edges
    next_st.sa_flag = sa_flag_new;
    next_st.drv_flag = drv_flag_new;

    // Register writes
    if (wr_analog) begin
      next_st.ctrl.analog_loop = req.wdata;
    end

    if (wr_remote) begin
      next_st.ctrl.remote_loop = req.wdata;
    end

    if (wr_ones) begin
      next_st.ctrl.force_ones = req.wdata;
    end

    if (wr_sa_mask) begin
      next_st.sa_mask = req.wdata;
    end

    if (wr_drv_mask) begin
      next_st.drv_mask = req.wdata;
    end

    if (wr_cfg_0e) begin
      next_st.x0e = req.wdata;
    end

    if (wr_cfg_0f) begin
      next_st.x0f = req.wdata;
    end

    if (wr_page) begin
      next_st.page = req.wdata;
    end

    // Soft reset runs for the whole cycle count
    if (wr_soft_reset) begin
      next_st.rst_busy = 1'b1;
      next_st.rst_cnt = rst_cnt_load;
    end else if (st.rst_busy) begin
      if (rst_last_cycle) begin
        next_st.rst_busy = 1'b0;
      end else begin
        next_st.rst_cnt = rst_cnt_dec;
      end
    end

    // Registers held at default while the reset cycle runs
    if (next_st.rst_busy) begin
      next_st.ctrl.analog_loop = `OLC_RST_ZERO;
      next_st.ctrl.remote_loop = `OLC_RST_ZERO;
      next_st.ctrl.force_ones = `OLC_RST_ZERO;

      next_st.sa_mask = `OLC_RST_ZERO;
      next_st.drv_mask = `OLC_RST_ZERO;

      next_st.sa_flag = `OLC_RST_ZERO;
      next_st.drv_flag = `OLC_RST_ZERO;

      next_st.sa_stat = `OLC_RST_ZERO;
      next_st.drv_stat = `OLC_RST_ZERO;

      next_st.x0e = `OLC_RST_ZERO;
      next_st.x0f = `OLC_RST_ZERO;
      next_st.page = `OLC_RST_ZERO;
    end

    // Request stands while any flag is set
    next_st.irq = (|next_st.sa_flag) | (|next_st.drv_flag);
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // Outputs come straight from the state flops
  assign host_rdata = st.rdata;
  assign line_ctrl = st.ctrl;
  assign irq_req = st.irq;
  assign soft_reset_busy = st.rst_busy;
endmodule : olc_ctrl_status
`default_nettype wire

// ===== design/olc_pkg.sv
`default_nettype none
package olc_pkg;
  typedef struct packed {
    logic rd;
    logic wr;
    logic [4:0] addr;
    logic [7:0] wdata;
  } olc_bus_req_t;
  typedef struct packed {
    logic [7:0] analog_loop;
    logic [7:0] remote_loop;
    logic [7:0] force_ones;
  } olc_ctrl_t;
  typedef struct packed {
    logic [7:0] sa_meta;
    logic [7:0] sa_sync;
    logic [7:0] drv_meta;
    logic [7:0] drv_sync;
    logic [7:0] xis_meta;
    logic [7:0] xis_sync;
    logic [7:0] sa_stat;
    logic [7:0] drv_stat;
    logic [7:0] sa_mask;
    logic [7:0] drv_mask;
    logic [7:0] sa_flag;
    logic [7:0] drv_flag;
    logic [7:0] x0e;
    logic [7:0] x0f;
    logic [7:0] page;
    olc_ctrl_t ctrl;
    logic [7:0] rdata;
    logic irq;
    logic [7:0] rst_cnt;
    logic rst_busy;
  } olc_state_t;
endpackage : olc_pkg
`default_nettype wire

// ===== design/olc_regs.svh
`ifndef OLC_REGS_SVH
`define OLC_REGS_SVH
`define OLC_ADDR_ID 5'h00
`define OLC_ADDR_ANALOG 5'h01
`define OLC_ADDR_REMOTE 5'h02
`define OLC_ADDR_ONES 5'h03
`define OLC_ADDR_SAS 5'h04
`define OLC_ADDR_DRVS 5'h05
`define OLC_ADDR_SAM 5'h06
`define OLC_ADDR_DRVM 5'h07
`define OLC_ADDR_SAF 5'h08
`define OLC_ADDR_DRVF 5'h09
`define OLC_ADDR_SRST 5'h0a
`define OLC_ADDR_XIS 5'h0d
`define OLC_ADDR_XC0E 5'h0e
`define OLC_ADDR_XC0F 5'h0f
`define OLC_ADDR_PAGE 5'h1f
`define OLC_RST_ZERO 8'h00
`define OLC_RST_TRIGGER_VAL 8'hff
// Identity value is arbitrary
`define OLC_ID_DEFAULT 8'h5a
`define OLC_SOFT_RESET_NS 1000
`define OLC_CLK_PERIOD_NS 5
`define OLC_SOFT_RESET_CYC (`OLC_SOFT_RESET_NS / `OLC_CLK_PERIOD_NS)
`endif

// ===== tb/olc_checker.sv
`timescale 1ns/1ps
`default_nettype none
`include "olc_regs.svh"
module olc_checker
  import olc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic host_rd,
  input wire logic host_wr,
  input wire logic irq_req,
  input wire logic soft_reset_busy,
  input wire logic [4:0] host_addr,
  input wire logic [7:0] host_wdata,
  input wire logic [7:0] host_rdata,
  input wire olc_ctrl_t line_ctrl
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  wire logic wq = host_wr && !soft_reset_busy;
  wire logic srst = wq && host_addr == 5'h0a;
  chk_id_value: assert property (host_rd && host_addr == 5'h00 |=>
    host_rdata == `OLC_ID_DEFAULT) else $error("id");
  chk_analog_wr: assert property (wq && host_addr == 5'h01 |=>
    line_ctrl.analog_loop == $past(host_wdata)) else $error("analog loop");
  chk_remote_wr: assert property (wq && host_addr == 5'h02 |=>
    line_ctrl.remote_loop == $past(host_wdata)) else $error("remote loop");
  chk_ones_wr: assert property (wq && host_addr == 5'h03 |=>
    line_ctrl.force_ones == $past(host_wdata)) else $error("force ones");
  chk_srst_start: assert property (srst |=> soft_reset_busy [*8]) else $error("busy");
  chk_srst_len: assert property ($rose(soft_reset_busy) |->
    ##199 soft_reset_busy ##1 !soft_reset_busy) else $error("len");
  chk_srst_clear: assert property (soft_reset_busy |->
    line_ctrl == '0 && !irq_req) else $error("clr");
  chk_rs_const: assert property (host_rd && host_addr == 5'h0a |=>
    host_rdata == 8'hff) else $error("trigger value");
endmodule : olc_checker
`default_nettype wire

// ===== tb/olc_line_model.sv
`timescale 1ns/1ps
`default_nettype none
module olc_line_model (
  input wire logic ref_clk,
  input wire logic [7:0] sa_flip,
  input wire logic [7:0] drv_flip,
  output logic [7:0] channel_signal_absent,
  output logic [7:0] channel_driver_fault
);
  initial {channel_signal_absent, channel_driver_fault} = '0;
  // Line faults toggle on request
  always @(posedge ref_clk) begin
    channel_signal_absent <= channel_signal_absent ^ sa_flip;
    channel_driver_fault <= channel_driver_fault ^ drv_flip;
  end
endmodule : olc_line_model
`default_nettype wire

// ===== tb/tb_octal_line_ctrl_status_regs.sv
`timescale 1ns/1ps
`default_nettype none
`include "olc_regs.svh"
module tb_octal_line_ctrl_status_regs;
  import olc_pkg::*;
  logic ref_clk = 0, nrst = 0, host_rd = 0, host_wr = 0, irq_req, soft_reset_busy;
  logic [4:0] host_addr = 0;
  logic [7:0] host_wdata = 0, host_rdata, sa, drv, xis = 8'hc3, p, m;
  logic [7:0] sa_flip = 0, drv_flip = 0;
  olc_ctrl_t line_ctrl;
  int err_total = 0, tests_run = 0, seed = 32'ha392a950, i, n;
  olc_ctrl_status DUT (.ref_clk, .nrst, .host_rd, .host_wr, .host_addr, .host_wdata,
    .channel_signal_absent(sa), .channel_driver_fault(drv), .expanded_indicator_status(xis),
    .host_rdata, .line_ctrl, .irq_req, .soft_reset_busy);
  olc_line_model u_line (.ref_clk, .sa_flip, .drv_flip, .channel_signal_absent(sa),
    .channel_driver_fault(drv));
  initial forever #2.5 ref_clk = ~ref_clk;
  task chk(input logic [7:0] x, s, input string nm);
    tests_run++;
    if (s !== x) begin
      err_total++;
      $display("ERROR %s exp %h got %h", nm, x, s);
    end
  endtask : chk
  task wr(input logic [4:0] a, input logic [7:0] d);
    host_addr = a;
    host_wdata = d;
    host_wr = 1;
    @(negedge ref_clk) host_wr = 0;
    @(negedge ref_clk);
  endtask : wr
  task rd(input logic [4:0] a, input logic [7:0] x);
    host_addr = a;
    host_rd = 1;
    @(negedge ref_clk) host_rd = 0;
    chk(x, host_rdata, $sformatf("reg %h", a));
    @(negedge ref_clk);
  endtask : rd
  function logic [7:0] rst_val(input logic [4:0] a);
    return a == `OLC_ADDR_ID ? `OLC_ID_DEFAULT : a == `OLC_ADDR_SRST ? `OLC_RST_TRIGGER_VAL :
      a == `OLC_ADDR_XIS ? xis : `OLC_RST_ZERO;
  endfunction : rst_val
  task print_verdict;
    if (err_total == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : print_verdict
  initial begin
    repeat (2) @(negedge ref_clk);
    nrst = 1;
    @(negedge ref_clk);
    for (i = 0; i < 32; i++) rd(i[4:0], rst_val(i[4:0]));
    for (i = 0; i < 12; i++) begin
      p = $random(seed);
      n = 1 + i % 3;
      wr(n[4:0], p);
      rd(n[4:0], p);
    end
    wr(5'h00, p);
    rd(5'h00, `OLC_ID_DEFAULT);
    for (i = 0; i < 6; i++) begin
      m = $random(seed);
      p = $random(seed);
      n = i % 2;
      wr(5'h06 + n[4:0], m);
      if (n == 0) sa_flip = p;
      else drv_flip = p;
      @(negedge ref_clk) {sa_flip, drv_flip} = 0;
      repeat (6) @(negedge ref_clk);
      chk({7'h0, |(p & m)}, {7'h0, irq_req}, "irq");
      rd(5'h08 + n[4:0], p & m);
      rd(5'h04 + n[4:0], n ? drv : sa);
      rd(5'h08 + n[4:0], 0);
      chk(0, {7'h0, irq_req}, "irq");
    end
    wr(5'h01, 8'hff);
    wr(5'h0a, p);
    for (n = 0; n < 300 && soft_reset_busy !== 0; n++) @(negedge ref_clk);
    chk(8'(`OLC_SOFT_RESET_CYC - 1), n[7:0], "busy");
    if (n < 300) begin
      rd(5'h01, 0);
      rd(5'h0a, `OLC_RST_TRIGGER_VAL);
    end
    print_verdict;
  end
endmodule : tb_octal_line_ctrl_status_regs
bind olc_ctrl_status olc_checker u_chk (.ref_clk, .nrst, .host_rd, .host_wr, .irq_req,
  .soft_reset_busy, .host_addr, .host_wdata, .host_rdata, .line_ctrl);
`default_nettype wire
